/* tmc_pkg.sv */
// Package with register map, field layout and reset values of the timer
package tmc_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_FLAGS   = 8'h0C;
  localparam logic [7:0] ADDR_IRQEN   = 8'h10;
  localparam logic [7:0] ADDR_PORT    = 8'h14;
  // Control register field positions
  localparam int CTL_CS_LSB  = 0;
  localparam int CTL_WGM_LSB = 3;
  localparam int CTL_COM_LSB = 5;
  localparam int CTL_FOC_BIT = 7;
  // Flag and enable bit positions
  localparam int FLG_OVF_BIT = 0;
  localparam int FLG_CMP_BIT = 1;
  // Port register bit positions
  localparam int PRT_OUT_BIT = 0;
  localparam int PRT_DIR_BIT = 1;
  // Reset values and count extremes
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [2:0] CS_STOPPED = 3'h0;
  // Waveform modes
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PHASE  = 2'h1;
  localparam logic [1:0] WGM_CTC    = 2'h2;
  localparam logic [1:0] WGM_FAST   = 2'h3;
  // Output modes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;
endpackage : tmc_pkg

/* tmc_timer.sv */
// Eight-bit timer counter, compare unit and compare output with APB access
`timescale 1ns/100ps
module tmc_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_tick,
  input  wire logic        compare_irq_ack,
  input  wire logic        overflow_irq_ack,
  output logic             compare_irq,
  output logic             overflow_irq,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             count_top,
  output logic             count_bottom
);

  // Register map seen from the bus, one byte-aligned word each
  // Control word: clock select in bits 2..0
  // Control word: waveform mode in bits 4..3
  // Control word: output mode in bits 6..5
  // Control word: force strobe in bit 7, acts once, reads back zero
  // Count word: low byte is the live counter
  // Compare word: buffer in PWM modes, comparator register otherwise
  // Flags word: bit 0 overflow, bit 1 compare match, write one to clear
  // Enables word: same bit layout as the flags word
  // Port word: bit 0 general port value, bit 1 pin direction
  // Unused bits read zero and ignore writes
  // Unmapped offsets answer with an error and change nothing
  // Interrupt lines are flag and enable, combined with no extra state
  // Service pulses clear the matching flag like a one written to it
  // Why one record: a single register process keeps freeze and reset
  // uniform, so no field can escape the enable by accident
  // All state of the block in one record
  typedef struct packed {
    logic [2:0] clock_select;
    logic [1:0] waveform_mode;
    logic [1:0] output_mode;
    logic [7:0] count_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic       count_down;
    logic       compare_match_flag;
    logic       overflow_flag;
    logic       compare_irq_enable;
    logic       overflow_irq_enable;
    logic       compare_output;
    logic       port_value;
    logic       output_pin_direction;
    logic       block_match;
    logic [31:0] rdata;
  } tmc_state_type;

  tmc_state_type state_ff;
  tmc_state_type nxt_state;

  logic       wr_acc;
  logic       rd_acc;
  logic       addr_ok;
  logic       tick;
  logic       is_pwm;
  logic       match;
  logic       at_top;
  logic       at_bottom;
  logic [7:0] top_value;

  // Bus timing in short
  // Setup edge: read data is captured into the record
  // Access edge: write takes effect, read data already stands
  // No wait states, so a master never needs a timeout here
  // Read data stands until the next read setup cycle
  // Trade-off: capturing at setup costs a register of 32 bits, but
  // keeps the read path free of the wide decode in the access cycle
  // Limitation: a count read returns the value before that edge
  // Writes while the enable is low are lost, not delayed
  // Zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign addr_ok = (paddr == tmc_pkg::ADDR_CONTROL) ||
                   (paddr == tmc_pkg::ADDR_COUNT)   ||
                   (paddr == tmc_pkg::ADDR_COMPARE) ||
                   (paddr == tmc_pkg::ADDR_FLAGS)   ||
                   (paddr == tmc_pkg::ADDR_IRQEN)   ||
                   (paddr == tmc_pkg::ADDR_PORT);
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = state_ff.rdata;

  // Tick only when a source is selected; source mapping lives outside
  assign tick = clk_en && timer_tick &&
                (state_ff.clock_select != tmc_pkg::CS_STOPPED);

  // Mode decode and extremes
  assign is_pwm = (state_ff.waveform_mode == tmc_pkg::WGM_PHASE) ||
                  (state_ff.waveform_mode == tmc_pkg::WGM_FAST);
  assign match  = (state_ff.count_value == state_ff.compare_value);
  assign at_top    = (state_ff.count_value == tmc_pkg::CNT_MAX);
  assign at_bottom = (state_ff.count_value == tmc_pkg::CNT_BOTTOM);
  assign top_value = (state_ff.waveform_mode == tmc_pkg::WGM_CTC) ?
                     state_ff.compare_value : tmc_pkg::CNT_MAX;

  // Outputs and the port override
  assign count_top    = at_top;
  assign count_bottom = at_bottom;
  assign compare_irq  = state_ff.compare_match_flag &&
                        state_ff.compare_irq_enable;
  assign overflow_irq = state_ff.overflow_flag &&
                        state_ff.overflow_irq_enable;
  assign pin_out = (state_ff.output_mode != tmc_pkg::COM_OFF) ?
                   state_ff.compare_output : state_ff.port_value;
  assign pin_oe  = state_ff.output_pin_direction;

  // Output actions by mode, in short
  // Off: the internal output state is left as it is
  // Toggle: inverts in non-PWM and fast modes, no action in phase mode
  // Clear: low on match; in phase mode low upcounting, high downcounting
  // Set: the inverse of clear in every mode
  // Fast mode also restores the idle level as the count wraps at top
  // The same function serves a forced match, so both paths agree
  // Hazard: mode bits are read live, so a change mid-period applies
  // at the very next match, which is what software asks for
  // Output action for a match under the current mode bits
  function automatic logic match_action(
    input logic [1:0] mode,
    input logic [1:0] wgm,
    input logic       cur,
    input logic       down
  );
    logic res;
    res = cur;
    if (mode == tmc_pkg::COM_TOGGLE) begin
      res = (wgm == tmc_pkg::WGM_PHASE) ? cur : !cur;
    end else if (mode == tmc_pkg::COM_CLEAR) begin
      res = (wgm == tmc_pkg::WGM_PHASE) ? down : 1'b0;
    end else if (mode == tmc_pkg::COM_SET) begin
      res = (wgm == tmc_pkg::WGM_PHASE) ? !down : 1'b1;
    end
    return res; // Off leaves state alone
  endfunction : match_action

  // Next-state order matters, later steps override earlier ones
  // First the tick: match, counting, overflow, output, buffer load
  // Then service pulses, which lose against a same-cycle set
  // Then register writes, so a count write beats any count step
  // Then read capture, which sees only the registered state
  // Last the enable, which throws the whole next state away
  // Count direction exists only in phase mode; others force it up
  // Match blocking lasts for one tick, stopped timer or not
  // Clear-on-match mode compares against its top, the compare value
  // Overflow in that mode needs a real wrap from maximum to zero
  // Phase mode flags overflow once per period, at bottom
  // Fast mode flags overflow as the count leaves maximum
  // Buffer load happens on the tick that sits at an extreme
  // Leaving a PWM mode, buffer and comparator are kept equal
  // Limitation: no prescaler here, ticks come from outside
  // Next-state logic: bus access, counter, compare and waveform
  always_comb begin
    logic eff_match;
    logic wrap;
    eff_match = 1'b0;
    wrap      = 1'b0;
    nxt_state = state_ff;
    if (tick) begin
      // Match seen on this tick unless a count write just blocked it
      eff_match = match && !state_ff.block_match;
      nxt_state.block_match = 1'b0;
      if (eff_match) begin
        nxt_state.compare_match_flag = 1'b1;
      end
      // Counting sequence by mode
      unique case (state_ff.waveform_mode)
        tmc_pkg::WGM_NORMAL: begin
          nxt_state.count_value = state_ff.count_value + 8'h01;
          wrap = at_top;
        end
        tmc_pkg::WGM_CTC: begin
          if (state_ff.count_value == top_value) begin
            nxt_state.count_value = tmc_pkg::CNT_BOTTOM;
          end else begin
            nxt_state.count_value = state_ff.count_value + 8'h01;
          end
          wrap = at_top && !match;
        end
        tmc_pkg::WGM_FAST: begin
          nxt_state.count_value = state_ff.count_value + 8'h01;
          wrap = at_top;
        end
        tmc_pkg::WGM_PHASE: begin
          // Dual slope: turn at the extremes, flag overflow at bottom
          if (at_top) begin
            nxt_state.count_down  = 1'b1;
            nxt_state.count_value = state_ff.count_value - 8'h01;
          end else if (at_bottom) begin
            nxt_state.count_down  = 1'b0;
            nxt_state.count_value = state_ff.count_value + 8'h01;
            wrap = 1'b1;
          end else if (state_ff.count_down) begin
            nxt_state.count_value = state_ff.count_value - 8'h01;
          end else begin
            nxt_state.count_value = state_ff.count_value + 8'h01;
          end
        end
      endcase
      if (state_ff.waveform_mode != tmc_pkg::WGM_PHASE) begin
        nxt_state.count_down = 1'b0;
      end
      if (wrap) begin
        nxt_state.overflow_flag = 1'b1;
      end
      // Output state; mode bits read live, never buffered
      if (eff_match) begin
        nxt_state.compare_output = match_action(state_ff.output_mode,
          state_ff.waveform_mode, state_ff.compare_output,
          state_ff.count_down);
      end
      if (state_ff.waveform_mode == tmc_pkg::WGM_FAST && at_top) begin
        if (state_ff.output_mode == tmc_pkg::COM_CLEAR) begin
          nxt_state.compare_output = 1'b1;
        end else if (state_ff.output_mode == tmc_pkg::COM_SET) begin
          nxt_state.compare_output = 1'b0;
        end
      end
      // Buffered compare loads at top or bottom only, avoiding odd pulses
      if (is_pwm && (at_top || at_bottom)) begin
        nxt_state.compare_value = state_ff.compare_buffer;
      end
    end
    // Outside PWM, the buffer follows the comparator value
    if (!is_pwm) begin
      nxt_state.compare_buffer = nxt_state.compare_value;
    end
    // Hardware service clears; a set in the same cycle wins
    if (compare_irq_ack && !(eff_match)) begin
      nxt_state.compare_match_flag = 1'b0;
    end
    if (overflow_irq_ack && !wrap) begin
      nxt_state.overflow_flag = 1'b0;
    end
    // Register writes
    if (clk_en && wr_acc) begin
      unique case (paddr)
        tmc_pkg::ADDR_CONTROL: begin
          nxt_state.clock_select  = pwdata[tmc_pkg::CTL_CS_LSB +: 3];
          nxt_state.waveform_mode = pwdata[tmc_pkg::CTL_WGM_LSB +: 2];
          nxt_state.output_mode   = pwdata[tmc_pkg::CTL_COM_LSB +: 2];
          // Force acts only outside PWM; no flag, no counter change
          if (pwdata[tmc_pkg::CTL_FOC_BIT] && !is_pwm) begin
            nxt_state.compare_output = match_action(
              pwdata[tmc_pkg::CTL_COM_LSB +: 2], state_ff.waveform_mode,
              state_ff.compare_output, state_ff.count_down);
          end
        end
        tmc_pkg::ADDR_COUNT: begin
          nxt_state.count_value = pwdata[7:0];
          nxt_state.block_match = 1'b1;
        end
        tmc_pkg::ADDR_COMPARE: begin
          nxt_state.compare_buffer = pwdata[7:0];
          if (!is_pwm) begin
            nxt_state.compare_value = pwdata[7:0];
          end
        end
        tmc_pkg::ADDR_FLAGS: begin
          // Write one to clear, but a same-cycle set survives
          if (pwdata[tmc_pkg::FLG_CMP_BIT] && !eff_match) begin
            nxt_state.compare_match_flag = 1'b0;
          end
          if (pwdata[tmc_pkg::FLG_OVF_BIT] && !wrap) begin
            nxt_state.overflow_flag = 1'b0;
          end
        end
        tmc_pkg::ADDR_IRQEN: begin
          nxt_state.compare_irq_enable  = pwdata[tmc_pkg::FLG_CMP_BIT];
          nxt_state.overflow_irq_enable = pwdata[tmc_pkg::FLG_OVF_BIT];
        end
        tmc_pkg::ADDR_PORT: begin
          nxt_state.port_value           = pwdata[tmc_pkg::PRT_OUT_BIT];
          nxt_state.output_pin_direction = pwdata[tmc_pkg::PRT_DIR_BIT];
        end
        default: ;
      endcase
    end
    // Read data captured at the setup cycle, valid in the access cycle
    if (clk_en && psel && !penable && !pwrite) begin
      nxt_state.rdata = 32'h0000_0000;
      unique case (paddr)
        tmc_pkg::ADDR_CONTROL: begin
          nxt_state.rdata[tmc_pkg::CTL_CS_LSB +: 3]  = state_ff.clock_select;
          nxt_state.rdata[tmc_pkg::CTL_WGM_LSB +: 2] = state_ff.waveform_mode;
          nxt_state.rdata[tmc_pkg::CTL_COM_LSB +: 2] = state_ff.output_mode;
        end
        tmc_pkg::ADDR_COUNT:
          nxt_state.rdata[7:0] = state_ff.count_value;
        tmc_pkg::ADDR_COMPARE:
          nxt_state.rdata[7:0] = is_pwm ? state_ff.compare_buffer :
                                 state_ff.compare_value;
        tmc_pkg::ADDR_FLAGS: begin
          nxt_state.rdata[tmc_pkg::FLG_CMP_BIT] = state_ff.compare_match_flag;
          nxt_state.rdata[tmc_pkg::FLG_OVF_BIT] = state_ff.overflow_flag;
        end
        tmc_pkg::ADDR_IRQEN: begin
          nxt_state.rdata[tmc_pkg::FLG_CMP_BIT] = state_ff.compare_irq_enable;
          nxt_state.rdata[tmc_pkg::FLG_OVF_BIT] = state_ff.overflow_irq_enable;
        end
        tmc_pkg::ADDR_PORT: begin
          nxt_state.rdata[tmc_pkg::PRT_OUT_BIT] = state_ff.port_value;
          nxt_state.rdata[tmc_pkg::PRT_DIR_BIT] =
            state_ff.output_pin_direction;
        end
        default: ;
      endcase
    end
    if (!clk_en) begin
      nxt_state = state_ff; // Enable low freezes everything
    end
  end

  // Register process notes
  // Reset clears every field, so the count starts at bottom
  // Reset leaves the pin released and both interrupts low
  // The enable is applied in the next-state logic, not here
  // That keeps this process free of anything but the reset
  // Reset is asynchronous on assertion; release must meet the clock
  // Only constants are loaded in the reset branch
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Closing notes for users of the block
  // Writing the count equal to the compare value loses that match
  // Preset the output state with a forced match before the pin drives
  // Both extremes are plain decodes and never stand together
  // Top value is maximum except in clear-on-match mode

endmodule : tmc_timer

/* tmc_cpu_model.sv */
// Processor model: APB master and interrupt service for the timer
`timescale 1ns/100ps
module tmc_cpu_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             compare_irq_ack,
  output logic             overflow_irq_ack
);
  // Idle bus from time zero
  initial begin
    psel             = 1'b0;
    penable          = 1'b0;
    pwrite           = 1'b0;
    paddr            = 8'h00;
    pwdata           = 32'h0;
    compare_irq_ack  = 1'b0;
    overflow_irq_ack = 1'b0;
  end

  // One transfer, entered just after a rising edge
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Slave may stretch the access; hold everything until it answers
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep showing the old value
    paddr   <= ~a;
    pwdata  <= ~d;
    @(posedge pclk);
  endtask : xfer

  // One-cycle service pulse, compare or overflow
  task ack(input logic cmp);
    compare_irq_ack  <= cmp;
    overflow_irq_ack <= !cmp;
    @(posedge pclk);
    compare_irq_ack  <= 1'b0;
    overflow_irq_ack <= 1'b0;
    @(posedge pclk);
  endtask : ack
endmodule : tmc_cpu_model

/* tmc_timer_chk.sv */
// Port-level assertions for the timer compare unit
`timescale 1ns/100ps
module tmc_timer_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_tick,
  input wire logic        compare_irq_ack,
  input wire logic        overflow_irq_ack,
  input wire logic        compare_irq,
  input wire logic        overflow_irq,
  input wire logic        pin_out,
  input wire logic        pin_oe,
  input wire logic        count_top,
  input wire logic        count_bottom
);
  logic wr_acc, tk, quiet, cack, oack, rd_set;
  // Frozen cycles (clk_en low) may change nothing
  assign wr_acc = psel && penable && pwrite && clk_en;
  assign tk     = timer_tick && clk_en;
  assign quiet  = !tk && !wr_acc;
  assign cack   = compare_irq_ack && clk_en && !timer_tick;
  assign oack   = overflow_irq_ack && clk_en && !timer_tick;
  assign rd_set = psel && !penable && !pwrite;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_cmp_ack: assert property (cack |=> !compare_irq)
    else $error("compare irq survived service");
  chk_ovf_ack: assert property (oack |=> !overflow_irq)
    else $error("overflow irq survived service");
  // Without tick or write the count cannot reach or leave an extreme
  chk_cnt_hold: assert property (
    quiet |=> $stable({count_top, count_bottom}))
    else $error("count extreme moved while idle");
  chk_ext_excl: assert property (!(count_top && count_bottom))
    else $error("top and bottom together");
  chk_cmp_rise: assert property ($rose(compare_irq) |-> !$past(quiet))
    else $error("compare irq rose without cause");
  chk_ovf_rise: assert property ($rose(overflow_irq) |-> !$past(quiet))
    else $error("overflow irq rose without cause");
  chk_oe_hold: assert property (!wr_acc |=> $stable(pin_oe))
    else $error("pin enable moved without write");
  chk_pin_hold: assert property (quiet |=> $stable(pin_out))
    else $error("pin moved without match or write");
  chk_rd_hold: assert property (!rd_set |=> $stable(prdata))
    else $error("read data moved outside read setup");

  cover property (cack && compare_irq);
  cover property ($rose(pin_oe));
  cover property (tk && count_top);
endmodule : tmc_timer_chk

bind tmc_timer tmc_timer_chk u_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_tick(timer_tick), .compare_irq_ack(compare_irq_ack),
  .overflow_irq_ack(overflow_irq_ack), .compare_irq(compare_irq),
  .overflow_irq(overflow_irq), .pin_out(pin_out), .pin_oe(pin_oe),
  .count_top(count_top), .count_bottom(count_bottom)
);

/* tmc_timer_tb_top.sv */
// Self-checking bench for the eight-bit timer compare unit
`timescale 1ns/100ps
module tmc_timer_tb_top;
  logic        pclk, presetn, clk_en, timer_tick, psel, penable, pwrite;
  logic        pready, pslverr, compare_irq_ack, overflow_irq_ack;
  logic        compare_irq, overflow_irq, pin_out, pin_oe;
  logic        count_top, count_bottom;
  logic [7:0]  paddr, v;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  int          errors, checks_done, seed;

  tmc_timer dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .compare_irq_ack(compare_irq_ack),
    .overflow_irq_ack(overflow_irq_ack), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq), .pin_out(pin_out), .pin_oe(pin_oe),
    .count_top(count_top), .count_bottom(count_bottom)
  );
  tmc_cpu_model cpu (
    .pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack)
  );

  task chk(input string nm, input logic [32:0] seen, input logic [32:0] e);
    checks_done++;
    if (seen !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk
  task w(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d);
  endtask : w
  // Note the expected {error, data} before the read goes out
  task r(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    cpu.xfer(1'b0, a, 32'h0);
  endtask : r
  task cw(input logic [2:0] c, input logic [1:0] g, input logic [1:0] o,
          input logic f);
    w(tmc_pkg::ADDR_CONTROL, {24'h0, f, o, g, c});
  endtask : cw
  // Ticks are one-cycle pulses with a gap between them
  task tick(input int n);
    repeat (n) begin
      timer_tick <= 1'b1;
      @(posedge pclk);
      timer_tick <= 1'b0;
      @(posedge pclk);
    end
  endtask : tick
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // Read result is taken at the access edge, oldest note first
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && exp_q.size() > 0)
      chk("read", {pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Whole run needs about 760 cycles
  initial begin
    #100000;
    errors++;
    stop_test();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    seed = 7;
    presetn = 1'b0;
    clk_en = 1'b1;
    timer_tick = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) r(8'(4 * i), 33'h0);
    r(8'h18, 33'h1_0000_0000);
    chk("ext", 33'({count_top, count_bottom}), 33'h1);
    $display("test reset done");
    w(tmc_pkg::ADDR_COMPARE, 32'h80);
    w(tmc_pkg::ADDR_COUNT, 32'hFE);
    w(tmc_pkg::ADDR_IRQEN, 32'h1);
    cw(3'h1, tmc_pkg::WGM_NORMAL, tmc_pkg::COM_OFF, 1'b0);
    tick(1);
    chk("top", 33'(count_top), 33'h1);
    tick(1);
    r(tmc_pkg::ADDR_COUNT, 33'h0);
    r(tmc_pkg::ADDR_FLAGS, 33'h1);
    chk("ovf_irq", 33'(overflow_irq), 33'h1);
    cpu.ack(1'b0);
    chk("ovf_irq", 33'(overflow_irq), 33'h0);
    $display("test wrap done");
    cw(3'h0, tmc_pkg::WGM_NORMAL, tmc_pkg::COM_OFF, 1'b0);
    w(tmc_pkg::ADDR_COUNT, 32'h37);
    tick(3);
    r(tmc_pkg::ADDR_COUNT, 33'h37);
    clk_en <= 1'b0;
    w(tmc_pkg::ADDR_COUNT, 32'hAA);
    clk_en <= 1'b1;
    r(tmc_pkg::ADDR_COUNT, 33'h37);
    repeat (4) begin
      v = 8'($random(seed));
      w(tmc_pkg::ADDR_COUNT, {24'h0, v});
      r(tmc_pkg::ADDR_COUNT, {25'h0, v});
    end
    $display("test stopped done");
    w(tmc_pkg::ADDR_IRQEN, 32'h2);
    w(tmc_pkg::ADDR_COMPARE, 32'h5);
    w(tmc_pkg::ADDR_COUNT, 32'h3);
    cw(3'h1, tmc_pkg::WGM_NORMAL, tmc_pkg::COM_OFF, 1'b0);
    tick(2);
    chk("cmp_irq", 33'(compare_irq), 33'h0);
    tick(1);
    chk("cmp_irq", 33'(compare_irq), 33'h1);
    cpu.ack(1'b1);
    chk("cmp_irq", 33'(compare_irq), 33'h0);
    // Count written equal to compare on purpose: the match is lost
    w(tmc_pkg::ADDR_COUNT, 32'h5);
    tick(2);
    r(tmc_pkg::ADDR_FLAGS, 33'h0);
    timer_tick <= 1'b1;
    w(tmc_pkg::ADDR_COUNT, 32'h20);
    timer_tick <= 1'b0;
    r(tmc_pkg::ADDR_COUNT, 33'h21);
    w(tmc_pkg::ADDR_COUNT, 32'hFE);
    cw(3'h1, tmc_pkg::WGM_PHASE, tmc_pkg::COM_OFF, 1'b0);
    tick(2);
    r(tmc_pkg::ADDR_COUNT, 33'hFE);
    $display("test match done");
    cw(3'h0, tmc_pkg::WGM_CTC, tmc_pkg::COM_OFF, 1'b0);
    w(tmc_pkg::ADDR_COMPARE, 32'h3);
    w(tmc_pkg::ADDR_COUNT, 32'h0);
    cw(3'h1, tmc_pkg::WGM_CTC, tmc_pkg::COM_OFF, 1'b0);
    tick(4);
    r(tmc_pkg::ADDR_COUNT, 33'h0);
    r(tmc_pkg::ADDR_FLAGS, 33'h2);
    w(tmc_pkg::ADDR_FLAGS, 32'h0);
    r(tmc_pkg::ADDR_FLAGS, 33'h2);
    w(tmc_pkg::ADDR_FLAGS, 32'h2);
    r(tmc_pkg::ADDR_FLAGS, 33'h0);
    tick(1);
    $display("test clear on match done");
    // Output state is preset by a forced match before the pin drives
    cw(3'h0, tmc_pkg::WGM_NORMAL, tmc_pkg::COM_TOGGLE, 1'b1);
    chk("pin", 33'({pin_oe, pin_out}), 33'h1);
    r(tmc_pkg::ADDR_FLAGS, 33'h0);
    r(tmc_pkg::ADDR_COUNT, 33'h1);
    w(tmc_pkg::ADDR_PORT, 32'h2);
    cw(3'h1, tmc_pkg::WGM_CTC, tmc_pkg::COM_OFF, 1'b0);
    tick(4);
    cw(3'h0, tmc_pkg::WGM_CTC, tmc_pkg::COM_TOGGLE, 1'b0);
    chk("pin", 33'({pin_oe, pin_out}), 33'h3);
    cw(3'h0, tmc_pkg::WGM_CTC, tmc_pkg::COM_OFF, 1'b0);
    chk("pin", 33'({pin_oe, pin_out}), 33'h2);
    w(tmc_pkg::ADDR_FLAGS, 32'h3);
    $display("test output done");
    cw(3'h0, tmc_pkg::WGM_FAST, tmc_pkg::COM_OFF, 1'b0);
    w(tmc_pkg::ADDR_COUNT, 32'h1);
    w(tmc_pkg::ADDR_COMPARE, 32'h40);
    r(tmc_pkg::ADDR_COMPARE, 33'h40);
    cw(3'h1, tmc_pkg::WGM_FAST, tmc_pkg::COM_OFF, 1'b0);
    tick(3);
    r(tmc_pkg::ADDR_FLAGS, 33'h2);
    tick(252);
    w(tmc_pkg::ADDR_FLAGS, 32'h3);
    tick(4);
    r(tmc_pkg::ADDR_FLAGS, 33'h0);
    $display("test buffered done");
    stop_test();
  end
endmodule : tmc_timer_tb_top
